// file: core/scg_pkg.sv
// Shared constants and carrier types for the safe clock start-up and gating block
package scg_pkg;

    // Synchronizer depth, never below two stages
    localparam int SCG_SYNC_STAGES = 2;
    // Width of the multi-bit crossing bus
    localparam int SCG_BUS_W = 8;
    // Width of the start-up delay count
    localparam int SCG_DELAY_W = 16;
    // Width of the reduced-rate divide value
    localparam int SCG_RATE_W = 8;
    // Width of the gap counter between state clear and write release
    localparam int SCG_GAP_W = 4;

    // Reset values of the counters
    localparam logic [SCG_DELAY_W-1:0] SCG_DELAY_RST = 16'h0000;
    localparam logic [SCG_RATE_W-1:0] SCG_RATE_RST = 8'h00;
    localparam logic [SCG_GAP_W-1:0] SCG_GAP_RST = 4'h0;
    // Cycles from state clear release to write release, minus one
    localparam logic [SCG_GAP_W-1:0] SCG_WRITE_GAP = 4'h2;

    // Constant levels of the double-rate output register, 180 degree shift
    localparam logic SCG_FIRST_EDGE_LEVEL = 1'b0;
    localparam logic SCG_SECOND_EDGE_LEVEL = 1'b1;

    // Start-up sequence phases
    typedef enum logic [2:0] {
        SCG_CLEAR,
        SCG_WRITE_HOLD,
        SCG_WAIT_LOCK,
        SCG_DELAY,
        SCG_RUN
    } scg_phase_t;

    // Controls of the double-rate output register driving the forwarded clock
    typedef struct packed {
        logic enable;
        logic set;
        logic reset;
        logic first_edge_input;
        logic second_edge_input;
    } scg_fwd_t;

    // Forwarded register reset value: stopped, low, constant edges kept
    localparam scg_fwd_t SCG_FWD_RST = '{
        enable: 1'b0,
        set: 1'b0,
        reset: 1'b1,
        first_edge_input: SCG_FIRST_EDGE_LEVEL,
        second_edge_input: SCG_SECOND_EDGE_LEVEL
    };

endpackage : scg_pkg

// file: core/scg_sync.sv
// Clock domain crossing synchronizer, single-bit or multi-bit variant
`timescale 1ns/100ps
module scg_sync
    import scg_pkg::*;
#(
    parameter int STAGES = SCG_SYNC_STAGES,
    parameter int WIDTH = 1,
    parameter bit MULTI_BIT = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // Whole state: flop chain, compare stage and held bus value
    typedef struct packed {
        logic [STAGES-1:0][WIDTH-1:0] chain;
        logic [WIDTH-1:0] cmp;
        logic [WIDTH-1:0] held;
    } scg_sync_state_t;

    scg_sync_state_t sync_q;
    scg_sync_state_t sync_d;

    // Chain shift; the first stage only feeds the second
    always_comb begin
        sync_d = sync_q;
        sync_d.chain[0] = async_in;
        for (int i = 1; i < STAGES; i++) begin
            sync_d.chain[i] = sync_q.chain[i-1];
        end
        sync_d.cmp = sync_q.chain[STAGES-1];
        // Bus only accepted when two settled samples agree, no torn words
        if (sync_q.cmp == sync_q.chain[STAGES-1]) begin
            sync_d.held = sync_q.cmp;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync_q <= '0;
        end else if (clk_en_in) begin
            sync_q <= sync_d;
        end
    end

    // Variant selection per crossing
    generate
        if (MULTI_BIT) begin : g_bus
            assign sync_out = sync_q.held;
        end else begin : g_bit
            assign sync_out = sync_q.chain[STAGES-1];
        end
    endgenerate

endmodule : scg_sync

// file: core/scg_top.sv
// Safe clock start-up, clock buffer gating and clock forwarding control
// What this block does
// - Logic is stopped through register clock enables, never clock path gates.
// - Idle networks are switched by the gated buffer enable.
// - Reduced rate comes from periodic pulses of the gated buffer enable.
// - A clock selector output switches the network from fast to slow source.
// - State clear is released first, register write release afterwards.
// - Clock stays disabled a configurable cycle count after reset release.
// - User buffer enable follows the synchronized lock indication.
// - A parallel second buffer clocks only the enable generating logic.
// - Critical state machines get clock enables and a synchronized local reset.
// - No clock is made by dividing a clock with a fabric counter.
// - Forwarded clock uses double-rate register with first 0, second 1.
// - Forwarded clock stops via register enable and set/reset at a chosen level.
// - Every asynchronous input crosses through a synchronizer.
// - Crossings come as single-bit and multi-bit variants.
// - Lock indication is synchronized before any logic uses it.
// - Logic clocked from the synthesizer is held in reset until lock.
`timescale 1ns/100ps
module scg_top
    import scg_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic synth_lock_indication_in,
    input wire logic startup_release_in,
    input wire logic [SCG_DELAY_W-1:0] startup_delay_in,
    input wire logic gate_request_in,
    input wire logic [SCG_RATE_W-1:0] rate_divide_in,
    input wire logic slow_select_in,
    input wire logic fwd_clock_stop_in,
    input wire logic fwd_stop_level_in,
    input wire logic cross_bit_in,
    input wire logic [SCG_BUS_W-1:0] cross_bus_in,
    output logic global_state_clear_out,
    output logic global_register_write_release_out,
    output logic user_buffer_enable_out,
    output logic ctrl_buffer_enable_out,
    output logic clock_selector_out,
    output logic user_reset_n_out,
    output logic fsm_enable_out,
    output logic startup_done_out,
    output scg_fwd_t fwd_ctrl_out,
    output logic cross_bit_out,
    output logic [SCG_BUS_W-1:0] cross_bus_out
);

    // Whole block state
    typedef struct packed {
        scg_phase_t phase;
        logic [SCG_DELAY_W-1:0] delay_cnt;
        logic [SCG_GAP_W-1:0] gap_cnt;
        logic [SCG_RATE_W-1:0] rate_cnt;
        logic state_clear;
        logic write_release;
        logic user_en;
        logic ctrl_en;
        logic clk_sel;
        logic user_rst_n;
        logic fsm_en;
        logic done;
        logic cross_bit;
        logic [SCG_BUS_W-1:0] cross_bus;
        scg_fwd_t fwd;
    } scg_state_t;

    scg_state_t st_q;
    scg_state_t st_d;
    logic [2:0] bits_sync;
    logic [SCG_BUS_W-1:0] bus_sync;
    logic lock_s;
    logic release_s;

    // lock synchronized before use, stage count parameter
    scg_sync #(
        .STAGES(SCG_SYNC_STAGES),
        .WIDTH(3),
        .MULTI_BIT(1'b0)
    ) u_bit_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .async_in({cross_bit_in, startup_release_in, synth_lock_indication_in}),
        .sync_out(bits_sync)
    );

    // multi-bit variant for the bus crossing
    scg_sync #(
        .STAGES(SCG_SYNC_STAGES),
        .WIDTH(SCG_BUS_W),
        .MULTI_BIT(1'b1)
    ) u_bus_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .async_in(cross_bus_in),
        .sync_out(bus_sync)
    );

    assign lock_s = bits_sync[0];
    assign release_s = bits_sync[1];

    // Start-up sequencer and enable generation
    // this logic belongs on the small parallel buffer, enabled by ctrl_en
    always_comb begin
        st_d = st_q;
        st_d.cross_bit = bits_sync[2];
        st_d.cross_bus = bus_sync;
        // source select registered, selector does the glitch-free switch
        st_d.clk_sel = slow_select_in;
        case (st_q.phase)
            SCG_CLEAR: begin
                // clear dropped first, write release waits for the gap
                if (release_s) begin
                    st_d.state_clear = 1'b0;
                    st_d.gap_cnt = SCG_WRITE_GAP;
                    st_d.phase = SCG_WRITE_HOLD;
                end
            end
            SCG_WRITE_HOLD: begin
                if (st_q.gap_cnt == SCG_GAP_RST) begin
                    st_d.write_release = 1'b1;
                    st_d.ctrl_en = 1'b1;
                    st_d.phase = SCG_WAIT_LOCK;
                end else begin
                    st_d.gap_cnt = st_q.gap_cnt - 4'h1;
                end
            end
            SCG_WAIT_LOCK: begin
                // user logic held in reset until lock
                if (lock_s) begin
                    st_d.user_rst_n = 1'b1;
                    st_d.delay_cnt = startup_delay_in;
                    st_d.phase = SCG_DELAY;
                end
            end
            SCG_DELAY: begin
                // lock loss restarts the whole delay
                if (!lock_s) begin
                    st_d.user_rst_n = 1'b0;
                    st_d.phase = SCG_WAIT_LOCK;
                // clock enabled only after the full delay
                end else if (st_q.delay_cnt == SCG_DELAY_RST) begin
                    st_d.user_en = 1'b1;
                    st_d.fsm_en = 1'b1;
                    st_d.done = 1'b1;
                    st_d.rate_cnt = SCG_RATE_RST;
                    st_d.phase = SCG_RUN;
                end else begin
                    st_d.delay_cnt = st_q.delay_cnt - 16'h0001;
                end
            end
            SCG_RUN: begin
                if (!lock_s) begin
                    st_d.user_en = 1'b0;
                    st_d.user_rst_n = 1'b0;
                    st_d.fsm_en = 1'b0;
                    st_d.done = 1'b0;
                    st_d.phase = SCG_WAIT_LOCK;
                // whole network switched off while idle
                end else if (gate_request_in) begin
                    st_d.user_en = 1'b0;
                end else if (rate_divide_in == SCG_RATE_RST) begin
                    st_d.user_en = 1'b1;
                    st_d.rate_cnt = SCG_RATE_RST;
                // one enabled edge per divide+1 cycles
                // enable pulses only, no fabric-divided clock
                end else if (st_q.rate_cnt == SCG_RATE_RST) begin
                    st_d.user_en = 1'b1;
                    st_d.rate_cnt = rate_divide_in;
                end else begin
                    st_d.user_en = 1'b0;
                    st_d.rate_cnt = st_q.rate_cnt - 8'h01;
                end
                // critical machines run only with a clean start
                st_d.fsm_en = st_d.user_en;
            end
            default: begin
                st_d.phase = SCG_CLEAR;
            end
        endcase
        // constant opposite edge levels give a 180 degree clock
        st_d.fwd.first_edge_input = SCG_FIRST_EDGE_LEVEL;
        st_d.fwd.second_edge_input = SCG_SECOND_EDGE_LEVEL;
        // stop holds the pin at the requested level
        st_d.fwd.enable = st_d.done && !fwd_clock_stop_in;
        st_d.fwd.set = !st_d.fwd.enable && fwd_stop_level_in;
        st_d.fwd.reset = !st_d.fwd.enable && !fwd_stop_level_in;
    end

    // state frozen by clock enable, never by a gated clock
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_q <= '{
                phase: SCG_CLEAR,
                delay_cnt: SCG_DELAY_RST,
                gap_cnt: SCG_GAP_RST,
                rate_cnt: SCG_RATE_RST,
                state_clear: 1'b1,
                cross_bus: '0,
                fwd: SCG_FWD_RST,
                default: 1'b0
            };
        end else if (clk_en_in) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign global_state_clear_out = st_q.state_clear;
    assign global_register_write_release_out = st_q.write_release;
    assign user_buffer_enable_out = st_q.user_en;
    assign ctrl_buffer_enable_out = st_q.ctrl_en;
    assign clock_selector_out = st_q.clk_sel;
    assign user_reset_n_out = st_q.user_rst_n;
    assign fsm_enable_out = st_q.fsm_en;
    assign startup_done_out = st_q.done;
    assign fwd_ctrl_out = st_q.fwd;
    assign cross_bit_out = st_q.cross_bit;
    assign cross_bus_out = st_q.cross_bus;

    // Helper: cycles from user reset release to start-up done
    logic [SCG_DELAY_W:0] rel_cnt_h;
    logic [SCG_DELAY_W-1:0] dly_h;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rel_cnt_h <= '0;
            dly_h <= SCG_DELAY_RST;
        end else if (clk_en_in) begin
            if (st_q.phase == SCG_WAIT_LOCK && lock_s) begin
                dly_h <= startup_delay_in;
            end
            if (!user_reset_n_out) begin
                rel_cnt_h <= '0;
            end else if (!startup_done_out) begin
                rel_cnt_h <= rel_cnt_h + 17'h00001;
            end
        end
    end

    // Checks, all in the system clock domain
    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in || !clk_en_in);

    clear_before_write_a: assert property (
        $fell(global_state_clear_out) |->
            !global_register_write_release_out [*3] ##1 global_register_write_release_out)
        else $error("write release not three cycles after state clear release");

    lock_gates_clock_a: assert property (
        !lock_s |=> !user_buffer_enable_out && !user_reset_n_out)
        else $error("user clock or reset active without lock");

    reset_until_lock_a: assert property (
        $rose(user_reset_n_out) |-> $past(lock_s))
        else $error("user reset released without lock");

    startup_delay_a: assert property (
        $rose(startup_done_out) |-> rel_cnt_h == {1'b0, dly_h} + 17'h00001)
        else $error("clock enabled before the start-up delay elapsed");

    relock_restart_a: assert property (
        (startup_done_out && !lock_s) |=> !startup_done_out ##1 !startup_done_out)
        else $error("start-up done kept after lock loss");

    gate_request_a: assert property (
        (gate_request_in && startup_done_out) |=> !user_buffer_enable_out)
        else $error("gated buffer enabled during idle request");

    rate_pulse_a: assert property (
        (st_q.rate_cnt != 8'h00 && rate_divide_in != 8'h00) |=> !user_buffer_enable_out)
        else $error("enable pulse inside the reduced-rate gap");

    fwd_stop_level_a: assert property (
        fwd_clock_stop_in |=> !fwd_ctrl_out.enable
            && fwd_ctrl_out.set == $past(fwd_stop_level_in)
            && fwd_ctrl_out.reset == !$past(fwd_stop_level_in))
        else $error("forwarded clock not held at stop level");

    fwd_edges_a: assert property (
        fwd_ctrl_out.enable |-> !fwd_ctrl_out.first_edge_input
            && fwd_ctrl_out.second_edge_input && !fwd_ctrl_out.set)
        else $error("forwarded clock edge levels wrong");

    lock_sync_a: assert property (
        ($past(rst_n_in, 3) && $past(clk_en_in, 1) && $past(clk_en_in, 2))
            |-> lock_s == $past(synth_lock_indication_in, 2))
        else $error("lock synchronizer latency not two cycles");

    fsm_clean_a: assert property (
        fsm_enable_out |-> user_reset_n_out && startup_done_out)
        else $error("critical machine enabled before clean start");

    // Main scenarios
    run_reached_c: cover property ($rose(startup_done_out));
    lock_loss_c: cover property (startup_done_out && !lock_s);
    rate_pulse_c: cover property (
        user_buffer_enable_out && rate_divide_in != 8'h00 ##1 !user_buffer_enable_out);
    fwd_stop_c: cover property (startup_done_out && fwd_clock_stop_in);

endmodule : scg_top

// file: sim/scg_partner.sv
// Far-side model: synthesizer lock source and user logic on the gated clock
`timescale 1ns/100ps
module scg_partner (
    input wire logic clk_sys_in,
    input wire logic lock_cmd_in,
    input wire logic user_buffer_enable_in,
    input wire logic user_reset_n_in,
    output logic synth_lock_indication_out,
    output int edges_out
);
    // Lock moves off the clock edge, as an unrelated source would
    initial synth_lock_indication_out = 1'b0;
    always @(lock_cmd_in) synth_lock_indication_out <= #2.3 lock_cmd_in;

    // User logic only sees an edge when the gated buffer lets one through
    initial edges_out = 0;
    always @(posedge clk_sys_in) begin
        if (user_buffer_enable_in === 1'b1 && user_reset_n_in === 1'b1) edges_out <= edges_out + 1;
    end
endmodule : scg_partner

// file: sim/tb_top.sv
// Self-checking bench for the start-up and gating block
`timescale 1ns/100ps
module tb_top;
    import scg_pkg::*;
    logic clk_sys_in, rst_n_in, lock_cmd, startup_release_in, gate_request_in, slow_select_in;
    logic fwd_clock_stop_in, fwd_stop_level_in, cross_bit_in, synth_lock_indication;
    logic [SCG_DELAY_W-1:0] startup_delay_in;
    logic [SCG_RATE_W-1:0] rate_divide_in;
    logic [SCG_BUS_W-1:0] cross_bus_in;
    logic clear, wrel, uen, cen, csel, urst_n, fen, done, cbit;
    logic [SCG_BUS_W-1:0] cbus;
    scg_fwd_t fwd;
    int edges, n_fail, checked, seed, last, npul, e0;
    logic cur, prev, clk_en;
    logic [31:0] rnd;

    scg_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
        .synth_lock_indication_in(synth_lock_indication), .startup_release_in(startup_release_in),
        .startup_delay_in(startup_delay_in), .gate_request_in(gate_request_in),
        .rate_divide_in(rate_divide_in), .slow_select_in(slow_select_in),
        .fwd_clock_stop_in(fwd_clock_stop_in), .fwd_stop_level_in(fwd_stop_level_in),
        .cross_bit_in(cross_bit_in), .cross_bus_in(cross_bus_in),
        .global_state_clear_out(clear), .global_register_write_release_out(wrel),
        .user_buffer_enable_out(uen), .ctrl_buffer_enable_out(cen), .clock_selector_out(csel),
        .user_reset_n_out(urst_n), .fsm_enable_out(fen), .startup_done_out(done),
        .fwd_ctrl_out(fwd), .cross_bit_out(cbit), .cross_bus_out(cbus));

    scg_partner i_partner (.clk_sys_in(clk_sys_in), .lock_cmd_in(lock_cmd),
        .user_buffer_enable_in(uen), .user_reset_n_in(urst_n),
        .synth_lock_indication_out(synth_lock_indication), .edges_out(edges));

    // 200 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // Verdict in one place only
    task automatic test_done;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_vec

    // Sample just after the edge, once its updates have landed
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            #1;
        end
    endtask : step

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = clear;
            1: pick = urst_n;
            default: pick = uen;
        endcase
    endfunction : pick

    // Bounded wait for a status bit to reach a level
    task automatic wait_for(input int sel, input logic lvl, input int limit);
        int i;
        for (i = 0; i < limit && pick(sel) !== lvl; i++) step(1);
        if (pick(sel) !== lvl) begin
            n_fail++;
            $display("[ERR] %0t wait ran out", $time);
            test_done();
        end
    endtask : wait_for

    // Lock seen: user reset lifts, clock held off D more cycles, then runs
    task automatic lock_start(input int d);
        int i;
        @(posedge clk_sys_in);
        startup_delay_in <= d[SCG_DELAY_W-1:0];
        lock_cmd <= 1'b1;
        wait_for(1, 1'b1, 12);
        for (i = 0; i < d; i++) begin
            step(1);
            chk_bit(uen, 1'b0, "early user enable");
        end
        step(1);
        chk_bit(uen, 1'b1, "user enable");
        chk_bit(done, 1'b1, "startup done");
        chk_bit(fen, 1'b1, "fsm enable");
    endtask : lock_start

    initial begin
        int n, k;
        seed = 32'h85aace08;
        n_fail = 0;
        checked = 0;
        rst_n_in = 1'b0;
        clk_en = 1'b1;
        lock_cmd = 1'b0;
        startup_release_in = 1'b0;
        startup_delay_in = 16'h0003;
        gate_request_in = 1'b0;
        rate_divide_in = 8'h00;
        slow_select_in = 1'b0;
        fwd_clock_stop_in = 1'b0;
        fwd_stop_level_in = 1'b0;
        cross_bit_in = 1'b0;
        cross_bus_in = 8'h00;
        step(3);
        // Reset values
        chk_bit(clear, 1'b1, "clear in reset");
        chk_bit(wrel, 1'b0, "write release in reset");
        chk_vec(16'(fwd), 16'(SCG_FWD_RST), "fwd in reset");
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        // Lock before writes are released must be ignored
        lock_cmd <= 1'b1;
        step(8);
        chk_bit(urst_n, 1'b0, "user reset before lock use");
        @(posedge clk_sys_in);
        lock_cmd <= 1'b0;
        startup_release_in <= 1'b1;
        wait_for(0, 1'b0, 12);
        // clear first, writes exactly three cycles later
        step(2);
        chk_bit(wrel, 1'b0, "write release early");
        step(1);
        chk_bit(wrel, 1'b1, "write release");
        chk_bit(cen, 1'b1, "control buffer enable");
        step(6);
        chk_bit(urst_n, 1'b0, "user reset without lock");
        lock_start(3);
        // Reduced rate through periodic enable pulses
        for (n = 1; n <= 3; n++) begin
            @(posedge clk_sys_in);
            rate_divide_in <= n[SCG_RATE_W-1:0];
            step(n + 4);
            last = -1;
            npul = 0;
            e0 = edges;
            for (k = 0; k < 6 * (n + 1); k++) begin
                step(1);
                chk_bit(fen, uen, "fsm follows enable");
                if (uen === 1'b1) begin
                    if (last >= 0) chk_vec(16'(k - last), 16'(n + 1), "pulse gap");
                    last = k;
                    npul++;
                end
            end
            chk_vec(16'(npul), 16'h0006, "pulse count");
            chk_vec(16'(edges - e0), 16'h0006, "user edges");
        end
        @(posedge clk_sys_in);
        rate_divide_in <= 8'h00;
        gate_request_in <= 1'b1;
        step(2);
        for (k = 0; k < 5; k++) begin
            chk_bit(uen, 1'b0, "gated idle");
            step(1);
        end
        @(posedge clk_sys_in);
        gate_request_in <= 1'b0;
        step(2);
        chk_bit(uen, 1'b1, "gate reopened");
        // Source selection follows the input one cycle later
        prev = 1'b0;
        for (k = 0; k < 16; k++) begin
            @(posedge clk_sys_in);
            rnd = $random(seed);
            cur = rnd[0];
            slow_select_in <= cur;
            #1;
            chk_bit(csel, prev, "selector");
            prev = cur;
        end
        // Clock enable low freezes all state, selector included
        @(posedge clk_sys_in);
        clk_en <= 1'b0;
        slow_select_in <= ~prev;
        step(3);
        chk_bit(csel, prev, "frozen selector");
        @(posedge clk_sys_in);
        clk_en <= 1'b1;
        step(1);
        chk_bit(csel, ~prev, "selector after thaw");
        // Forwarded clock stop at both levels, then run
        for (k = 0; k < 2; k++) begin
            @(posedge clk_sys_in);
            fwd_clock_stop_in <= 1'b1;
            fwd_stop_level_in <= k[0];
            step(3);
            chk_vec(16'(fwd), 16'({1'b0, k[0], ~k[0], 2'b01}), "fwd stopped");
            @(posedge clk_sys_in);
            fwd_clock_stop_in <= 1'b0;
            step(3);
            chk_bit(fwd.enable, 1'b1, "fwd running");
            chk_bit(fwd.first_edge_input, 1'b0, "first edge level");
            chk_bit(fwd.second_edge_input, 1'b1, "second edge level");
        end
        // Single-bit and bus crossings
        for (k = 0; k < 12; k++) begin
            @(posedge clk_sys_in);
            rnd = $random(seed);
            cross_bit_in <= rnd[0];
            cross_bus_in <= rnd[15:8];
            step(3);
            chk_bit(cbit, cross_bit_in, "bit crossing");
            step(5);
            chk_vec(16'(cbus), 16'(cross_bus_in), "bus crossing");
        end
        // Lock loss stops the clock and restarts the delay
        @(posedge clk_sys_in);
        lock_cmd <= 1'b0;
        wait_for(2, 1'b0, 6);
        chk_bit(done, 1'b0, "done after lock loss");
        chk_bit(urst_n, 1'b0, "reset after lock loss");
        chk_bit(fen, 1'b0, "fsm after lock loss");
        step(5);
        lock_start(5);
        test_done();
    end
endmodule : tb_top
